// ==== pbcr_map.svh ====
// register map constants for the port phy basic control block
`ifndef PBCR_MAP_SVH
`define PBCR_MAP_SVH
`define PBCR_PHYAD_FIRST 5'h01
`define PBCR_PHYAD_LAST 5'h04
`define PBCR_REG_CTRL 5'h00
`define PBCR_REG_LAST_STD 5'h05
`define PBCR_REG_VEND_A 5'h1d
`define PBCR_REG_VEND_B 5'h1f
`define PBCR_SPI_BASE 8'h10
`define PBCR_SPI_STRIDE 8'h10
`define PBCR_CTRL_RESET 16'h3120
`define PBCR_CTRL_WMASK 16'hff3f
`define PBCR_BIT_SRST 15
`define PBCR_BIT_LOOP 14
`define PBCR_BIT_SPEED 13
`define PBCR_BIT_AN_EN 12
`define PBCR_BIT_PDOWN 11
`define PBCR_BIT_ISO 10
`define PBCR_BIT_AN_RST 9
`define PBCR_BIT_DUPLEX 8
`define PBCR_BIT_XVAR 5
`define PBCR_BIT_WIRE 4
`define PBCR_BIT_XDIS 3
`define PBCR_BIT_FEF 2
`define PBCR_BIT_TXDIS 1
`define PBCR_BIT_LEDOFF 0
`endif

// ==== pbcr_pkg.sv ====
// types for the port phy basic control block
package pbcr_pkg;
   typedef enum logic [1:0] {
      PBCR_SRC_NONE,
      PBCR_SRC_MIIM,
      PBCR_SRC_SPI
   } pbcr_src_t;
endpackage

// ==== pbcr_ctrl_mem.sv ====
// per-port control word storage with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "pbcr_map.svh"
module pbcr_ctrl_mem #(
   parameter int PORTS = 4
) (
   input wire logic i_clk, // system clock
   input wire logic i_rst, // async reset, active high
   input wire logic i_wr, // write strobe
   input wire logic [1:0] i_wr_port, // port being written
   input wire logic [15:0] i_wr_data, // masked value to store
   input wire logic [PORTS-1:0] i_srst, // per-port soft reset pulse
   input wire logic [1:0] i_rd_port, // port being read
   output logic [15:0] o_rd_data, // registered read word
   output logic [16*PORTS-1:0] o_all // all control words
);
   // ****************************************
   // storage
   // ****************************************
   logic [15:0] word_reg [PORTS]; // one control word per port
   // write, soft reset and reset to defaults
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int p = 0; p < PORTS; p++) begin
            word_reg[p] <= `PBCR_CTRL_RESET;
         end
      end else begin
         for (int p = 0; p < PORTS; p++) begin
            if (i_srst[p]) begin
               word_reg[p] <= `PBCR_CTRL_RESET;
            end else if (i_wr && (i_wr_port == p[1:0])) begin
               word_reg[p] <= i_wr_data;
            end
         end
      end
   end
   // registered read port
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data <= 16'h0000;
      end else begin
         o_rd_data <= word_reg[i_rd_port];
      end
   end
   // flat view of all words
   always_comb begin
      for (int p = 0; p < PORTS; p++) begin
         o_all[16*p +: 16] = word_reg[p];
      end
   end
endmodule
`default_nettype wire

// ==== pbcr_top.sv ====
// port phy basic control register bank with miim and spi access
//
// Contract
// - phy addresses one to four select ports
// - only registers 0-5, 29, 31 answer
// - spi port reaches same registers, other mapping
// - bit 15 soft reset, self clearing
// - bit 14 turns traffic around at mac
// - bit 13 forced speed, resets one
// - bit 12 autonegotiation enable, resets one
// - bit 11 power down, resets zero
// - bit 10 isolates transmit pair
// - bit 9 restarts autonegotiation
// - bit 8 forced duplex, resets one
// - bit 5 crossover variant, resets one
// - bit 4 forced wiring when crossover off
// - bit 3 disables automatic crossover
// - bit 2 disables far end fault
// - bit 1 suppresses transmitter
// - bit 0 switches off leds
`timescale 1ns/100ps
`default_nettype none
`include "pbcr_map.svh"
module pbcr_top #(
   parameter int PORTS = 4
) (
   input wire logic I_SYS_CLK, // system clock 250 mhz
   input wire logic I_RST, // async reset, active high
   input wire logic I_MIIM_REQ, // miim access strobe, one cycle
   input wire logic I_MIIM_WR, // 1 write, 0 read
   input wire logic [4:0] I_MIIM_PHYAD, // phy address
   input wire logic [4:0] I_MIIM_REGAD, // register address
   input wire logic [15:0] I_MIIM_WDATA, // write data
   output logic O_MIIM_ACK, // access done pulse
   output logic O_MIIM_ERR, // address not answered
   output logic [15:0] O_MIIM_RDATA, // read data
   input wire logic I_SPI_REQ, // spi access strobe, one cycle
   input wire logic I_SPI_WR, // 1 write, 0 read
   input wire logic [7:0] I_SPI_ADDR, // spi word address
   input wire logic [15:0] I_SPI_WDATA, // write data
   output logic O_SPI_ACK, // access done pulse
   output logic O_SPI_ERR, // address not answered
   output logic [15:0] O_SPI_RDATA, // read data
   output logic [PORTS-1:0] O_PHY_RESET, // soft reset pulse per port
   output logic [PORTS-1:0] O_MAC_LOOPBACK, // mac loopback per port
   output logic [PORTS-1:0] O_SPEED_100, // forced speed 100
   output logic [PORTS-1:0] O_AUTONEG_ENABLE, // autoneg enabled
   output logic [PORTS-1:0] O_POWER_DOWN, // power down
   output logic [PORTS-1:0] O_LINE_ISOLATE, // isolate tx pair
   output logic [PORTS-1:0] O_AUTONEG_RESTART, // restart pulse
   output logic [PORTS-1:0] O_FULL_DUPLEX, // forced full duplex
   output logic [PORTS-1:0] O_CROSSOVER_VARIANT_SELECT, // variant
   output logic [PORTS-1:0] O_FORCED_WIRING_SELECT, // 1 mdi 0 mdix
   output logic [PORTS-1:0] O_AUTO_CROSSOVER_DISABLE, // no auto x
   output logic [PORTS-1:0] O_FAR_END_FAULT_DISABLE, // fef off
   output logic [PORTS-1:0] O_TX_DISABLE, // transmitter off
   output logic [PORTS-1:0] O_LED_DISABLE // leds off
);
   // ****************************************
   // address decode helpers
   // ****************************************
   // true for register numbers that answer
   function automatic logic reg_ok(input logic [4:0] ra);
      reg_ok = (ra <= `PBCR_REG_LAST_STD) || (ra == `PBCR_REG_VEND_A) ||
         (ra == `PBCR_REG_VEND_B);
   endfunction

   // ****************************************
   // request arbitration and decode
   // ****************************************
   pbcr_pkg::pbcr_src_t src; // which port is served now
   logic hit; // address answered
   logic [1:0] port; // port index
   logic [4:0] regad; // register within port
   logic wr; // write request
   logic [15:0] wdata; // write data
   logic [7:0] spi_off; // spi offset above base
   logic spi_pend_reg; // spi held while miim served
   logic spi_wr_reg; // held spi direction
   logic [7:0] spi_addr_reg; // held spi address
   logic [15:0] spi_wdata_reg; // held spi data
   logic spi_go; // spi request to serve

   assign spi_go = I_SPI_REQ || spi_pend_reg;
   assign spi_off = (spi_pend_reg ? spi_addr_reg : I_SPI_ADDR) -
      `PBCR_SPI_BASE;

   // miim wins, a colliding spi request is held until a cycle without miim request
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         spi_pend_reg <= 1'b0;
         spi_wr_reg <= 1'b0;
         spi_addr_reg <= 8'h00;
         spi_wdata_reg <= 16'h0000;
      end else if (I_MIIM_REQ && I_SPI_REQ && !spi_pend_reg) begin
         spi_pend_reg <= 1'b1;
         spi_wr_reg <= I_SPI_WR;
         spi_addr_reg <= I_SPI_ADDR;
         spi_wdata_reg <= I_SPI_WDATA;
      end else if (!I_MIIM_REQ) begin
         spi_pend_reg <= 1'b0;
      end
   end

   // decode of the served request
   always_comb begin
      src = pbcr_pkg::PBCR_SRC_NONE;
      hit = 1'b0;
      port = 2'd0;
      regad = 5'h00;
      wr = 1'b0;
      wdata = 16'h0000;
      if (I_MIIM_REQ) begin
         src = pbcr_pkg::PBCR_SRC_MIIM;
         wr = I_MIIM_WR;
         wdata = I_MIIM_WDATA;
         regad = I_MIIM_REGAD;
         port = 2'(I_MIIM_PHYAD - `PBCR_PHYAD_FIRST);
         hit = (I_MIIM_PHYAD >= `PBCR_PHYAD_FIRST) &&
            (I_MIIM_PHYAD <= `PBCR_PHYAD_LAST) && reg_ok(I_MIIM_REGAD);
      end else if (spi_go) begin
         // spi: port block of 16 words from base, word index low bits
         src = pbcr_pkg::PBCR_SRC_SPI;
         wr = spi_pend_reg ? spi_wr_reg : I_SPI_WR;
         wdata = spi_pend_reg ? spi_wdata_reg : I_SPI_WDATA;
         port = spi_off[5:4];
         regad = {1'b0, spi_off[3:0]};
         if (spi_off[3:0] == 4'hd) begin
            regad = `PBCR_REG_VEND_A;
         end else if (spi_off[3:0] == 4'hf) begin
            regad = `PBCR_REG_VEND_B;
         end
         hit = (spi_off < 8'(PORTS * 16)) && reg_ok(regad);
      end
   end

   // ****************************************
   // control word storage
   // ****************************************
   logic ctrl_wr; // write to a control word
   logic [15:0] ctrl_wdata; // stored value
   logic [PORTS-1:0] srst; // soft reset request per port
   logic [15:0] ctrl_rd; // registered read word
   logic [16*PORTS-1:0] ctrl_all; // every control word

   assign ctrl_wr = hit && wr && (regad == `PBCR_REG_CTRL);
   // self clearing bits never stored; reserved bits dropped
   assign ctrl_wdata = wdata & `PBCR_CTRL_WMASK &
      ~(16'h0001 << `PBCR_BIT_SRST) & ~(16'h0001 << `PBCR_BIT_AN_RST);

   always_comb begin
      for (int p = 0; p < PORTS; p++) begin
         srst[p] = ctrl_wr && (port == p[1:0]) && wdata[`PBCR_BIT_SRST];
      end
   end

   pbcr_ctrl_mem #(
      .PORTS(PORTS)
   ) u_mem (
      .i_clk(I_SYS_CLK),
      .i_rst(I_RST),
      .i_wr(ctrl_wr),
      .i_wr_port(port),
      .i_wr_data(ctrl_wdata),
      .i_srst(srst),
      .i_rd_port(port),
      .o_rd_data(ctrl_rd),
      .o_all(ctrl_all)
   );

   // ****************************************
   // answer path
   // ****************************************
   pbcr_pkg::pbcr_src_t src_reg; // source of access in flight
   logic hit_reg; // access answered
   logic ctrl_sel_reg; // read targets control word

   // stage one: remember what was asked
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         src_reg <= pbcr_pkg::PBCR_SRC_NONE;
         hit_reg <= 1'b0;
         ctrl_sel_reg <= 1'b0;
      end else begin
         src_reg <= src;
         hit_reg <= hit;
         ctrl_sel_reg <= (regad == `PBCR_REG_CTRL);
      end
   end

   // stage two: ack, error and data; others read zero here
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_MIIM_ACK <= 1'b0;
         O_MIIM_ERR <= 1'b0;
         O_MIIM_RDATA <= 16'h0000;
         O_SPI_ACK <= 1'b0;
         O_SPI_ERR <= 1'b0;
         O_SPI_RDATA <= 16'h0000;
      end else begin
         O_MIIM_ACK <= (src_reg == pbcr_pkg::PBCR_SRC_MIIM);
         O_MIIM_ERR <= (src_reg == pbcr_pkg::PBCR_SRC_MIIM) && !hit_reg;
         O_SPI_ACK <= (src_reg == pbcr_pkg::PBCR_SRC_SPI);
         O_SPI_ERR <= (src_reg == pbcr_pkg::PBCR_SRC_SPI) && !hit_reg;
         if (src_reg == pbcr_pkg::PBCR_SRC_MIIM) begin
            O_MIIM_RDATA <= (hit_reg && ctrl_sel_reg) ? ctrl_rd : 16'h0000;
         end
         if (src_reg == pbcr_pkg::PBCR_SRC_SPI) begin
            O_SPI_RDATA <= (hit_reg && ctrl_sel_reg) ? ctrl_rd : 16'h0000;
         end
      end
   end

   // ****************************************
   // per-port control outputs
   // ****************************************
   // one-cycle strobes from self clearing bits
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_PHY_RESET <= '0;
         O_AUTONEG_RESTART <= '0;
      end else begin
         O_PHY_RESET <= srst;
         for (int p = 0; p < PORTS; p++) begin
            O_AUTONEG_RESTART[p] <= ctrl_wr && (port == p[1:0]) &&
               wdata[`PBCR_BIT_AN_RST] && !wdata[`PBCR_BIT_SRST];
         end
      end
   end

   // level controls follow the stored words
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_MAC_LOOPBACK <= '0;
         O_SPEED_100 <= '1;
         O_AUTONEG_ENABLE <= '1;
         O_POWER_DOWN <= '0;
         O_LINE_ISOLATE <= '0;
         O_FULL_DUPLEX <= '1;
         O_CROSSOVER_VARIANT_SELECT <= '1;
         O_FORCED_WIRING_SELECT <= '0;
         O_AUTO_CROSSOVER_DISABLE <= '0;
         O_FAR_END_FAULT_DISABLE <= '0;
         O_TX_DISABLE <= '0;
         O_LED_DISABLE <= '0;
      end else begin
         for (int p = 0; p < PORTS; p++) begin
            O_MAC_LOOPBACK[p] <= ctrl_all[16*p+`PBCR_BIT_LOOP];
            O_SPEED_100[p] <= ctrl_all[16*p+`PBCR_BIT_SPEED];
            O_AUTONEG_ENABLE[p] <= ctrl_all[16*p+`PBCR_BIT_AN_EN];
            O_POWER_DOWN[p] <= ctrl_all[16*p+`PBCR_BIT_PDOWN];
            O_LINE_ISOLATE[p] <= ctrl_all[16*p+`PBCR_BIT_ISO];
            O_FULL_DUPLEX[p] <= ctrl_all[16*p+`PBCR_BIT_DUPLEX];
            O_CROSSOVER_VARIANT_SELECT[p] <=
               ctrl_all[16*p+`PBCR_BIT_XVAR];
            O_FORCED_WIRING_SELECT[p] <=
               ctrl_all[16*p+`PBCR_BIT_WIRE];
            O_AUTO_CROSSOVER_DISABLE[p] <=
               ctrl_all[16*p+`PBCR_BIT_XDIS];
            O_FAR_END_FAULT_DISABLE[p] <=
               ctrl_all[16*p+`PBCR_BIT_FEF];
            O_TX_DISABLE[p] <= ctrl_all[16*p+`PBCR_BIT_TXDIS];
            O_LED_DISABLE[p] <= ctrl_all[16*p+`PBCR_BIT_LEDOFF];
         end
      end
   end
endmodule
`default_nettype wire

// ==== pbcr_top_chk.sv ====
// assertion checker for the port phy basic control bank
`timescale 1ns/100ps
`default_nettype none
module pbcr_top_chk #(
   parameter int PORTS = 4
) (
   input wire logic I_SYS_CLK, // clock
   input wire logic I_RST, // reset
   input wire logic I_MIIM_REQ, // miim strobe
   input wire logic I_MIIM_WR, // miim write
   input wire logic [4:0] I_MIIM_PHYAD, // phy address
   input wire logic [4:0] I_MIIM_REGAD, // register address
   input wire logic [15:0] I_MIIM_WDATA, // write data
   input wire logic O_MIIM_ACK, // miim done
   input wire logic O_MIIM_ERR, // miim refused
   input wire logic [15:0] O_MIIM_RDATA, // read data
   input wire logic I_SPI_REQ, // spi strobe
   input wire logic O_SPI_ACK, // spi done
   input wire logic [PORTS-1:0] O_PHY_RESET, // reset pulses
   input wire logic [PORTS-1:0] O_AUTONEG_RESTART, // restart pulses
   input wire logic [PORTS-1:0] O_MAC_LOOPBACK, // loopback
   input wire logic [PORTS-1:0] O_SPEED_100, // speed
   input wire logic [PORTS-1:0] O_FULL_DUPLEX // duplex
);
   default clocking @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);
   logic ctl1; // write to the port one control word
   logic reg_ok; // register address that answers
   assign ctl1 = I_MIIM_REQ && I_MIIM_WR && I_MIIM_PHYAD == 5'h01
      && I_MIIM_REGAD == 5'h00;
   assign reg_ok = I_MIIM_REGAD <= 5'h05 || I_MIIM_REGAD == 5'h1d
      || I_MIIM_REGAD == 5'h1f;
   // soft reset pulse, then defaults back on the levels
   sequence srst_seq;
      O_PHY_RESET[0] ##1 (!O_PHY_RESET[0] && O_SPEED_100[0]
         && !O_MAC_LOOPBACK[0]);
   endsequence
   // restart is a single cycle pulse
   sequence restart_seq;
      O_AUTONEG_RESTART[0] ##1 !O_AUTONEG_RESTART[0];
   endsequence
   ack_two_a: assert property (I_MIIM_REQ |-> ##2 O_MIIM_ACK)
      else $error("miim ack not two cycles after request");
   bad_phy_a: assert property (
      I_MIIM_REQ && (I_MIIM_PHYAD == 5'h00 || I_MIIM_PHYAD > 5'h04)
      |-> ##2 (O_MIIM_ACK && O_MIIM_ERR))
      else $error("unknown phy address not refused");
   reg_set_a: assert property (
      I_MIIM_REQ && I_MIIM_PHYAD inside {[5'h01:5'h04]}
      |-> ##2 (O_MIIM_ERR == !$past(reg_ok, 2)))
      else $error("register address answer wrong");
   spi_ack_a: assert property (
      I_SPI_REQ && !I_MIIM_REQ |-> ##2 O_SPI_ACK)
      else $error("spi ack not two cycles after request");
   soft_reset_a: assert property (
      ctl1 && I_MIIM_WDATA[15] |-> ##1 srst_seq)
      else $error("soft reset pulse or restore wrong");
   an_restart_a: assert property (
      ctl1 && I_MIIM_WDATA[9] && !I_MIIM_WDATA[15] |-> ##1 restart_seq)
      else $error("restart pulse wrong");
   level_copy_a: assert property (
      ctl1 && !I_MIIM_WDATA[15] |-> ##2
      (O_MAC_LOOPBACK[0] == $past(I_MIIM_WDATA[14], 2)
      && O_SPEED_100[0] == $past(I_MIIM_WDATA[13], 2)
      && O_FULL_DUPLEX[0] == $past(I_MIIM_WDATA[8], 2)))
      else $error("control levels do not follow write");
   read_zero_a: assert property (
      O_MIIM_ACK |-> (O_MIIM_RDATA & 16'h82c0) == 16'h0000)
      else $error("self clearing or reserved bits read one");
endmodule
bind pbcr_top pbcr_top_chk #(.PORTS(PORTS)) i_chk (.*);
`default_nettype wire

// ==== pbcr_smc_model.sv ====
// station management controller model issuing one-cycle strobes
`timescale 1ns/100ps
`default_nettype none
module pbcr_smc_model #(
   parameter int AW = 10
) (
   input wire logic i_clk, // system clock
   output logic o_req, // access strobe
   output logic o_wr, // 1 write 0 read
   output logic [AW-1:0] o_addr, // target address
   output logic [15:0] o_wdata, // write data
   input wire logic i_ack, // access done
   input wire logic i_err, // not answered
   input wire logic [15:0] i_rdata // read data
);
   initial begin
      o_req = 1'b0;
      o_wr = 1'b0;
      o_addr = '0;
      o_wdata = 16'h0000;
   end
   // one access: strobe one cycle, released lines inverted, wait answer
   task automatic access(input logic wr, input logic [AW-1:0] a,
         input logic [15:0] d, output logic [15:0] q, output logic e);
      int n;
      @(posedge i_clk);
      o_req <= 1'b1;
      o_wr <= wr;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_req <= 1'b0;
      o_wr <= ~wr;
      o_addr <= ~a;
      o_wdata <= ~d;
      n = 0;
      do begin
         // answer taken at the rising edge where ack is seen high
         @(posedge i_clk);
         n++;
      end while (i_ack !== 1'b1 && n < 8);
      q = i_rdata;
      e = (n < 8) ? i_err : 1'bx;
   endtask
endmodule
`default_nettype wire

// ==== pbcr_top_test.sv ====
// self-checking bench for the port phy basic control bank
`timescale 1ns/100ps
`default_nettype none
module pbcr_top_test;
   logic I_SYS_CLK, I_RST, I_MIIM_REQ, I_MIIM_WR, O_MIIM_ACK, O_MIIM_ERR;
   logic I_SPI_REQ, I_SPI_WR, O_SPI_ACK, O_SPI_ERR;
   logic [4:0] I_MIIM_PHYAD, I_MIIM_REGAD;
   logic [7:0] I_SPI_ADDR;
   logic [15:0] I_MIIM_WDATA, O_MIIM_RDATA, I_SPI_WDATA, O_SPI_RDATA;
   logic [3:0] O_PHY_RESET, O_MAC_LOOPBACK, O_SPEED_100, O_AUTONEG_ENABLE;
   logic [3:0] O_POWER_DOWN, O_LINE_ISOLATE, O_AUTONEG_RESTART;
   logic [3:0] O_FULL_DUPLEX, O_CROSSOVER_VARIANT_SELECT;
   logic [3:0] O_FORCED_WIRING_SELECT, O_AUTO_CROSSOVER_DISABLE;
   logic [3:0] O_FAR_END_FAULT_DISABLE, O_TX_DISABLE, O_LED_DISABLE;
   logic [3:0] seen_rs, seen_ar; // pulses caught since last clear
   int miscompares = 0;
   int tests_run = 0;
   pbcr_top #(.PORTS(4)) i_dut (.*);
   logic [9:0] mi_addr; // miim phy and register address from the model
   assign I_MIIM_PHYAD = mi_addr[9:5];
   assign I_MIIM_REGAD = mi_addr[4:0];
   pbcr_smc_model #(.AW(10)) i_mi (.i_clk(I_SYS_CLK), .o_req(I_MIIM_REQ),
      .o_wr(I_MIIM_WR), .o_addr(mi_addr),
      .o_wdata(I_MIIM_WDATA), .i_ack(O_MIIM_ACK), .i_err(O_MIIM_ERR),
      .i_rdata(O_MIIM_RDATA));
   pbcr_smc_model #(.AW(8)) i_sp (.i_clk(I_SYS_CLK), .o_req(I_SPI_REQ),
      .o_wr(I_SPI_WR), .o_addr(I_SPI_ADDR), .o_wdata(I_SPI_WDATA),
      .i_ack(O_SPI_ACK), .i_err(O_SPI_ERR), .i_rdata(O_SPI_RDATA));
   initial begin
      I_SYS_CLK = 1'b0;
      forever #2 I_SYS_CLK = ~I_SYS_CLK;
   end
   // collect one-cycle pulses so a task can judge them afterwards
   always @(posedge I_SYS_CLK) begin
      seen_rs = seen_rs | O_PHY_RESET;
      seen_ar = seen_ar | O_AUTONEG_RESTART;
   end
   // the twelve level outputs of one port, in control bit order
   function automatic logic [15:0] lv(input int p);
      return {4'h0, O_MAC_LOOPBACK[p], O_SPEED_100[p], O_AUTONEG_ENABLE[p],
         O_POWER_DOWN[p], O_LINE_ISOLATE[p], O_FULL_DUPLEX[p],
         O_CROSSOVER_VARIANT_SELECT[p], O_FORCED_WIRING_SELECT[p],
         O_AUTO_CROSSOVER_DISABLE[p], O_FAR_END_FAULT_DISABLE[p],
         O_TX_DISABLE[p], O_LED_DISABLE[p]};
   endfunction
   function automatic logic [15:0] ex(input logic [15:0] w);
      return {4'h0, w[14:10], w[8], w[5:0]};
   endfunction
   task automatic chk(input string nm, input logic [15:0] s,
         input logic [15:0] x);
      tests_run++;
      if (s !== x) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic t_reset();
      logic [15:0] q;
      logic e;
      for (int p = 0; p < 4; p++) begin
         chk("levels", lv(p), ex(16'h3120));
         i_mi.access(1'b0, {5'(p + 1), 5'h00}, 16'h0000, q, e);
         chk("ctrl", q, 16'h3120);
         chk("err", {15'h0, e}, 16'h0000);
      end
      $display("test reset done");
   endtask
   task automatic t_addr();
      logic [15:0] q;
      logic e;
      logic [4:0] rg [6] = '{5'h01, 5'h05, 5'h06, 5'h1d, 5'h1e, 5'h1f};
      for (int p = 0; p < 6; p++) begin
         i_mi.access(1'b0, {5'(p), 5'h00}, 16'h0000, q, e);
         chk("phy err", {15'h0, e}, {15'h0, p == 0 || p == 5});
      end
      for (int i = 0; i < 6; i++) begin
         i_mi.access(1'b1, {5'h01, rg[i]}, 16'h0000, q, e);
         i_mi.access(1'b0, {5'h01, rg[i]}, 16'h0000, q, e);
         chk("reg err", {15'h0, e}, {15'h0, i == 2 || i == 4});
         chk("reg data", q, 16'h0000);
      end
      i_mi.access(1'b0, 10'h020, 16'h0000, q, e);
      chk("ctrl kept", q, 16'h3120);
      $display("test addr done");
   endtask
   task automatic t_bits();
      logic [15:0] q;
      logic e;
      for (int p = 0; p < 4; p++) begin
         i_mi.access(1'b1, {5'(p + 1), 5'h00}, 16'h7dff, q, e);
         i_mi.access(1'b0, {5'(p + 1), 5'h00}, 16'h0000, q, e);
         chk("rdback", q, 16'h7d3f);
         chk("levels", lv(p),
            ex(16'h7d3f));
         chk("loop map", {12'h0, O_MAC_LOOPBACK}, 16'(1 << p));
         i_mi.access(1'b1, {5'(p + 1), 5'h00}, 16'h0000, q, e);
         chk("cleared", lv(p), 16'h0000);
      end
      $display("test bits done");
   endtask
   task automatic t_pulse();
      logic [15:0] q;
      logic e;
      seen_rs = 4'h0;
      seen_ar = 4'h0;
      i_mi.access(1'b1, 10'h020, 16'h0200, q, e);
      i_mi.access(1'b0, 10'h020, 16'h0000, q, e);
      chk("restart", {8'h0, seen_ar, seen_rs}, 16'h0010);
      chk("rd restart", q, 16'h0000);
      i_mi.access(1'b1, 10'h020, 16'hc000, q, e);
      i_mi.access(1'b0, 10'h020, 16'h0000, q, e);
      chk("soft rst", {8'h0, seen_ar, seen_rs}, 16'h0011);
      chk("rd srst", q, 16'h3120);
      chk("lv srst", lv(0), ex(16'h3120));
      $display("test pulse done");
   endtask
   task automatic t_spi();
      logic [15:0] q;
      logic e;
      logic [7:0] sa [5] = '{8'h30, 8'h1d, 8'h16, 8'h50, 8'h0f};
      logic [15:0] q2; // spi read data in the colliding access
      logic e2; // spi error in the colliding access
      i_sp.access(1'b1, 8'h30, 16'h4000, q, e);
      chk("spi loop", {12'h0, O_MAC_LOOPBACK}, 16'h0004);
      i_mi.access(1'b0, {5'h03, 5'h00}, 16'h0000, q, e);
      chk("miim view", q, 16'h4000);
      for (int i = 0; i < 5; i++) begin
         i_sp.access(1'b0, sa[i], 16'h0000, q, e);
         chk("spi err", {15'h0, e}, {15'h0, i >= 2});
         chk("spi data", q, (i == 0) ? 16'h4000 : 16'h0000);
      end
      // both hosts in one cycle: miim first, spi held and served after
      fork
         i_mi.access(1'b1, {5'h02, 5'h00}, 16'h0001, q, e);
         i_sp.access(1'b0, 8'h30, 16'h0000, q2, e2);
      join
      chk("held spi", q2, 16'h4000);
      chk("held err", {15'h0, e2}, 16'h0000);
      chk("miim first", lv(1), ex(16'h0001));
      $display("test spi done");
   endtask
   initial begin
      seen_rs = 4'h0;
      seen_ar = 4'h0;
      I_RST = 1'b1;
      repeat (6) @(posedge I_SYS_CLK);
      I_RST <= 1'b0;
      t_reset();
      t_addr();
      t_bits();
      t_pulse();
      t_spi();
      test_done();
   end
   // cut a hang short well beyond the expected few hundred cycles
   initial begin
      #20000;
      miscompares++;
      test_done();
   end
endmodule
`default_nettype wire
